/* common/tvpi2c_pkg.sv */
// tvpi2c_pkg: constants of the serial control port of the video processor
// assumes: single 250 MHz system clock, pins sampled into that domain
package tvpi2c_pkg;
    // ========================================================
    // bus addressing
    localparam logic [6:0] SLAVE_ADDR = 7'h45;
    localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
    localparam int FAST_MODE_BIT_RATE_KBPS = 400;
    // ========================================================
    // subaddress map
    localparam logic [7:0] CTRL_FIRST = 8'h02;
    localparam logic [7:0] CTRL_LAST = 8'h30;
    localparam logic [7:0] RESERVED_FIRST = 8'hFC;
    localparam int CTRL_WORDS = 47;
    localparam logic [7:0] WIDE_BLANKING_TIMING = 8'h03;
    localparam logic [7:0] COLOUR_DECODER_CTRL_A = 8'h20;
    localparam logic [7:0] COLOUR_DECODER_CTRL_B = 8'h21;
    localparam logic [7:0] CATHODE_CTRL = 8'h2A;
    localparam logic [7:0] OUTPUT_STAGE_CTRL = 8'h2B;
    localparam logic [7:0] FEATURE_CTRL_B = 8'h2E;
    // ========================================================
    // field positions
    localparam int AUTO_COLOUR_LIMIT_BIT = 1;
    localparam int FORCED_COLOUR_ON_BIT = 0;
    localparam int ONE_POINT_LOOP_BIT = 7;
    localparam int EXT_FORMAT_LSB = 1;
    localparam int WIDE_BLANK_EN_BIT = 0;
    localparam int OVERSHOOT_LSB = 4;
    localparam int WBLANK_FALL_LSB = 4;
    localparam int WBLANK_RISE_LSB = 0;
    localparam int SCREEN_GRID_BIT = 2;
    localparam int CATHODE_LEVEL_LSB = 0;
    localparam int IN_WINDOW_BIT = 3;
    localparam int HIGH_LOW_BIT = 2;
    // ========================================================
    // reset values
    localparam logic [7:0] WBLANK_RESET = 8'h88;
    localparam logic [7:0] DEFAULT_RESET = 8'h00;
    localparam logic [3:0] CATHODE_FIXED_LEVEL = 4'h0;
    // ========================================================
    // status set and deflection register holding the test flag
    localparam int STATUS_BYTES = 5;
    localparam logic [7:0] DEFLECTION_CTRL = 8'h26;
endpackage : tvpi2c_pkg

/* rtl/tvpi2c_sync.sv */
// tvpi2c_sync: two-flop synchroniser for one asynchronous level
// assumes: input changes slowly against clk_sys
`timescale 1ns/1ps
`default_nettype none
module tvpi2c_sync
(
    input wire logic clk_sys, // system clock
    input wire logic sys_rst, // async reset, high
    input wire logic async_in, // level from a pin
    output logic sync_out // level in clk_sys domain
);
    logic meta_ff;
    // ========================================================
    // meta_ff is read by sync_out only; idle bus level is high
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta_ff <= 1'b1;
            sync_out <= 1'b1;
        end
        else
        begin
            meta_ff <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule : tvpi2c_sync
`default_nettype wire

/* rtl/tvpi2c_regfile.sv */
// tvpi2c_regfile: write-only control bytes of the customer range
// assumes: write strobe is one cycle and comes from the bus engine
`timescale 1ns/1ps
`default_nettype none
module tvpi2c_regfile
#(
    parameter int WORDS = tvpi2c_pkg::CTRL_WORDS
)
(
    input wire logic clk_sys, // system clock
    input wire logic sys_rst, // async reset, high
    input wire logic wr_en, // one-cycle write strobe
    input wire logic [7:0] wr_addr, // subaddress
    input wire logic [7:0] wr_data, // data byte
    output logic [WORDS*8-1:0] regs_flat // all control bytes
);
    logic [7:0] mem_ff [WORDS];
    // ========================================================
    // each location kept as flops so every control bit is live
    genvar gi;
    generate
        for (gi = 0; gi < WORDS; gi++)
        begin : g_loc
            localparam logic [7:0] LOC = 8'(gi) + tvpi2c_pkg::CTRL_FIRST;
            localparam logic [7:0] RV =
                (LOC == tvpi2c_pkg::WIDE_BLANKING_TIMING) ?
                tvpi2c_pkg::WBLANK_RESET : tvpi2c_pkg::DEFAULT_RESET;
            always_ff @(posedge clk_sys or posedge sys_rst)
            begin
                if (sys_rst)
                    mem_ff[gi] <= RV;
                else if (wr_en && wr_addr == LOC)
                    mem_ff[gi] <= wr_data;
            end
            assign regs_flat[gi*8 +: 8] = mem_ff[gi];
        end
    endgenerate
endmodule : tvpi2c_regfile
`default_nettype wire

/* rtl/tvpi2c_ctrl_port.sv */
// tvpi2c_ctrl_port: serial control slave of the video processor
// assumes: open-drain bus pins resolved outside; analog status
// comparator levels arrive as asynchronous pins
// Function
// - answer only own seven-bit address
// - ignore the all-zero general call
// - fast-mode slave, master at most 400k
// - forty-seven writable control bytes, rest unused
// - control locations are write only
// - status read only as whole auto-increment burst
// - grid test inserts black, compares currents
// - window flags reported in status byte one
// - vertical scan kept running during test
// - forced colour overrides colour killer
// - colour limit enable reduces chroma only
// - two-bit external input format select
// - one-point loop replaces continuous calibration
// - one-point mode ignores cathode drive level
// - wide blanking enable on RGB outputs
// - wide blanking edges from timing register
// - two-bit overshoot ratio for peaking
`timescale 1ns/1ps
`default_nettype none
module tvpi2c_ctrl_port
#(
    parameter int WORDS = tvpi2c_pkg::CTRL_WORDS
)
(
    input wire logic clk_sys, // system clock 250 MHz
    input wire logic sys_rst, // async reset, high
    input wire logic scl_in, // bus clock pin level
    input wire logic sda_in, // bus data pin level
    output logic sda_out, // data drive value (always low)
    output logic sda_oe, // data pull-down enable
    input wire logic [7:0] status0_in, // status byte zero from core
    input wire logic [7:0] status2_in, // status byte two
    input wire logic [7:0] status3_in, // status byte three
    input wire logic [7:0] status4_in, // status byte four
    input wire logic cur_in_window_in, // comparator: in window
    input wire logic cur_high_low_in, // comparator: outside window
    output logic forced_colour_on, // colour killer override
    output logic auto_colour_limit_en, // chroma limiter on
    output logic [1:0] ext_input_format_sel, // RGB or YUV input
    output logic one_point_loop_sel, // one-point black loop
    output logic continuous_cathode_calibration, // full calibration
    output logic [3:0] cathode_drive_level, // effective drive level
    output logic wide_blank_en, // wide blanking active
    output logic [7:0] wide_blank_edge_timing, // fall/rise timing
    output logic [1:0] overshoot_ratio, // peaking overshoot ratio
    output logic screen_grid_adjust_mode, // grid test active
    output logic black_insert, // fixed black on RGB outputs
    output logic vertical_scan_en // vertical scan running
);
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_ADDR = 6'b000010,
        ST_ACK = 6'b000100,
        ST_WRITE = 6'b001000,
        ST_READ = 6'b010000,
        ST_RACK = 6'b100000
    } tvpi2c_state_t;

    logic scl_s, sda_s, scl_d_ff, sda_d_ff;
    logic scl_rise, scl_fall, start_det, stop_det;
    tvpi2c_state_t state_ff;
    logic [7:0] shift_ff;
    logic [3:0] bitcnt_ff;
    logic rw_ff, sub_ff, ack_ok_ff;
    logic [7:0] ptr_ff;
    logic [2:0] stat_ff;
    logic wr_en_ff;
    logic [7:0] wr_addr_ff, wr_data_ff;
    logic [WORDS*8-1:0] regs_flat;
    logic win_s, hl_s;
    logic [7:0] status1;
    logic [7:0] stat_cur, r_timing, r_dec_a, r_dec_b, r_defl, r_cath;
    logic [7:0] r_outs, r_feat;

    tvpi2c_sync u_scl (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .async_in(scl_in), .sync_out(scl_s));
    tvpi2c_sync u_sda (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .async_in(sda_in), .sync_out(sda_s));
    tvpi2c_sync u_win (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .async_in(cur_in_window_in), .sync_out(win_s));
    tvpi2c_sync u_hl (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .async_in(cur_high_low_in), .sync_out(hl_s));

    tvpi2c_regfile #(.WORDS(WORDS)) u_regs (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .wr_en(wr_en_ff), .wr_addr(wr_addr_ff),
        .wr_data(wr_data_ff), .regs_flat(regs_flat));

    function automatic logic [7:0] reg_at(input logic [7:0] a,
        input logic [WORDS*8-1:0] f);
        int idx;
        idx = int'(a) - int'(tvpi2c_pkg::CTRL_FIRST);
        reg_at = f[idx*8 +: 8];
    endfunction : reg_at

    // ========================================================
    // bus edge detection, all on synchronised levels
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end
        else
        begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
    end
    assign scl_rise = scl_s && !scl_d_ff;
    assign scl_fall = !scl_s && scl_d_ff;
    assign start_det = scl_s && scl_d_ff && !sda_s && sda_d_ff;
    assign stop_det = scl_s && scl_d_ff && sda_s && !sda_d_ff;

    // window flags in status byte one
    assign status1 = {4'h0, win_s && screen_grid_adjust_mode,
        hl_s && screen_grid_adjust_mode, 2'b00};

    function automatic logic [7:0] stat_byte(input logic [2:0] i,
        input logic [7:0] s0, input logic [7:0] s1,
        input logic [7:0] s2, input logic [7:0] s3,
        input logic [7:0] s4);
        case (i)
            3'h0: stat_byte = s0;
            3'h1: stat_byte = s1;
            3'h2: stat_byte = s2;
            3'h3: stat_byte = s3;
            3'h4: stat_byte = s4;
            default: stat_byte = 8'hFF;
        endcase
    endfunction : stat_byte

    // a select on a function result is not legal, so name each byte
    assign stat_cur = stat_byte(stat_ff, status0_in, status1, status2_in,
        status3_in, status4_in);
    assign r_timing = reg_at(tvpi2c_pkg::WIDE_BLANKING_TIMING, regs_flat);
    assign r_dec_a = reg_at(tvpi2c_pkg::COLOUR_DECODER_CTRL_A, regs_flat);
    assign r_dec_b = reg_at(tvpi2c_pkg::COLOUR_DECODER_CTRL_B, regs_flat);
    assign r_defl = reg_at(tvpi2c_pkg::DEFLECTION_CTRL, regs_flat);
    assign r_cath = reg_at(tvpi2c_pkg::CATHODE_CTRL, regs_flat);
    assign r_outs = reg_at(tvpi2c_pkg::OUTPUT_STAGE_CTRL, regs_flat);
    assign r_feat = reg_at(tvpi2c_pkg::FEATURE_CTRL_B, regs_flat);

    // ========================================================
    // protocol engine; sampling on scl rise, driving on scl fall
    // slave timing driven purely by master edges
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_ff <= ST_IDLE;
            shift_ff <= 8'h00;
            bitcnt_ff <= 4'h0;
            rw_ff <= 1'b0;
            sub_ff <= 1'b0;
            ack_ok_ff <= 1'b0;
            ptr_ff <= 8'h00;
            stat_ff <= 3'h0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            wr_en_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            wr_data_ff <= 8'h00;
        end
        else
        begin
            wr_en_ff <= 1'b0;
            sda_out <= 1'b0;
            if (start_det)
            begin
                state_ff <= ST_ADDR;
                bitcnt_ff <= 4'h0;
                sda_oe <= 1'b0;
            end
            else if (stop_det)
            begin
                state_ff <= ST_IDLE;
                sda_oe <= 1'b0;
            end
            else
            begin
                case (state_ff)
                    ST_IDLE:
                        sda_oe <= 1'b0;
                    ST_ADDR, ST_WRITE:
                    begin
                        if (scl_rise && bitcnt_ff < 4'h8)
                        begin
                            shift_ff <= {shift_ff[6:0], sda_s};
                            bitcnt_ff <= bitcnt_ff + 4'h1;
                        end
                        else if (scl_fall && bitcnt_ff == 4'h8)
                        begin
                            if (state_ff == ST_ADDR)
                            begin
                                ack_ok_ff <= shift_ff[7:1] ==
                                    tvpi2c_pkg::SLAVE_ADDR;
                                sda_oe <= shift_ff[7:1] ==
                                    tvpi2c_pkg::SLAVE_ADDR;
                                rw_ff <= shift_ff[0];
                                sub_ff <= 1'b0;
                                stat_ff <= 3'h0;
                            end
                            else if (!sub_ff)
                            begin
                                ptr_ff <= shift_ff;
                                sub_ff <= 1'b1;
                                sda_oe <= 1'b1;
                            end
                            else
                            begin
                                wr_en_ff <= ptr_ff >=
                                    tvpi2c_pkg::CTRL_FIRST &&
                                    ptr_ff <= tvpi2c_pkg::CTRL_LAST;
                                wr_addr_ff <= ptr_ff;
                                wr_data_ff <= shift_ff;
                                ptr_ff <= ptr_ff + 8'h01;
                                sda_oe <= 1'b1;
                            end
                            state_ff <= ST_ACK;
                        end
                    end
                    ST_ACK:
                    begin
                        if (scl_fall)
                        begin
                            bitcnt_ff <= 4'h0;
                            if (state_ff == ST_ACK && !ack_ok_ff)
                            begin
                                sda_oe <= 1'b0;
                                state_ff <= ST_IDLE;
                            end
                            else if (rw_ff)
                            begin
                                shift_ff <= stat_cur;
                                sda_oe <= !stat_cur[7];
                                state_ff <= ST_READ;
                            end
                            else
                            begin
                                sda_oe <= 1'b0;
                                state_ff <= ST_WRITE;
                            end
                        end
                    end
                    ST_READ:
                    begin
                        if (scl_fall)
                        begin
                            if (bitcnt_ff == 4'h7)
                            begin
                                sda_oe <= 1'b0;
                                state_ff <= ST_RACK;
                                stat_ff <= stat_ff + 3'h1;
                            end
                            else
                            begin
                                sda_oe <= !shift_ff[6];
                                shift_ff <= {shift_ff[6:0], 1'b1};
                                bitcnt_ff <= bitcnt_ff + 4'h1;
                            end
                        end
                    end
                    ST_RACK:
                    begin
                        // master nack ends the burst
                        if (scl_rise)
                            state_ff <= sda_s ? ST_IDLE : ST_ACK;
                    end
                    default:
                    begin
                        state_ff <= ST_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ========================================================
    // control bit routing, registered so outputs come from flops
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            forced_colour_on <= 1'b0;
            auto_colour_limit_en <= 1'b0;
            ext_input_format_sel <= 2'b00;
            one_point_loop_sel <= 1'b0;
            continuous_cathode_calibration <= 1'b1;
            cathode_drive_level <= 4'h0;
            wide_blank_en <= 1'b0;
            wide_blank_edge_timing <= tvpi2c_pkg::WBLANK_RESET;
            overshoot_ratio <= 2'b00;
            screen_grid_adjust_mode <= 1'b0;
            black_insert <= 1'b0;
            vertical_scan_en <= 1'b1;
        end
        else
        begin
            forced_colour_on <= r_dec_b[tvpi2c_pkg::FORCED_COLOUR_ON_BIT];
            auto_colour_limit_en <= r_dec_a[tvpi2c_pkg::AUTO_COLOUR_LIMIT_BIT];
            ext_input_format_sel <= r_outs[tvpi2c_pkg::EXT_FORMAT_LSB +: 2];
            one_point_loop_sel <= r_outs[tvpi2c_pkg::ONE_POINT_LOOP_BIT];
            continuous_cathode_calibration <=
                !r_outs[tvpi2c_pkg::ONE_POINT_LOOP_BIT];
            // drive level fixed in one-point mode
            cathode_drive_level <= r_outs[tvpi2c_pkg::ONE_POINT_LOOP_BIT] ?
                tvpi2c_pkg::CATHODE_FIXED_LEVEL :
                r_cath[tvpi2c_pkg::CATHODE_LEVEL_LSB +: 4];
            wide_blank_en <= r_outs[tvpi2c_pkg::WIDE_BLANK_EN_BIT];
            wide_blank_edge_timing <= r_timing;
            overshoot_ratio <= r_feat[tvpi2c_pkg::OVERSHOOT_LSB +: 2];
            screen_grid_adjust_mode <= r_defl[tvpi2c_pkg::SCREEN_GRID_BIT];
            black_insert <= r_defl[tvpi2c_pkg::SCREEN_GRID_BIT];
            // scan never stopped by the test
            vertical_scan_en <= 1'b1;
        end
    end
endmodule : tvpi2c_ctrl_port
`default_nettype wire

/* verification/tvpi2c_ctrl_port_asserts.sv */
// checker for the serial control port, bound to its top module
// assumes: bus pins are sampled raw, outputs are registered
`timescale 1ns/1ps
`default_nettype none
module tvpi2c_ctrl_port_asserts
#(
    parameter int WORDS = tvpi2c_pkg::CTRL_WORDS
)
(
    input wire logic clk_sys, // system clock
    input wire logic sys_rst, // async reset, high
    input wire logic scl_in, // bus clock pin
    input wire logic sda_out, // data drive value
    input wire logic sda_oe, // data pull-down enable
    input wire logic forced_colour_on, // colour killer override
    input wire logic auto_colour_limit_en, // chroma limiter
    input wire logic [1:0] ext_input_format_sel, // input format
    input wire logic one_point_loop_sel, // one-point loop
    input wire logic continuous_cathode_calibration, // full loop
    input wire logic [3:0] cathode_drive_level, // drive level
    input wire logic wide_blank_en, // wide blanking
    input wire logic [7:0] wide_blank_edge_timing, // edge timing
    input wire logic [1:0] overshoot_ratio, // peaking ratio
    input wire logic screen_grid_adjust_mode, // grid test
    input wire logic black_insert, // fixed black
    input wire logic vertical_scan_en // vertical scan
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    // ========================================================
    // properties
    property p_open_drain;
        sda_out == 1'b0;
    endproperty
    property p_oe_moves_low;
        $changed(sda_oe) |-> !scl_in;
    endproperty
    // a driven bit must outlast any glitch filter of the master
    property p_ack_holds;
        $rose(sda_oe) |=> sda_oe [*8];
    endproperty
    property p_ctrl_on_low;
        $changed({forced_colour_on, auto_colour_limit_en,
            ext_input_format_sel, one_point_loop_sel, wide_blank_en,
            wide_blank_edge_timing, overshoot_ratio,
            screen_grid_adjust_mode}) |-> !scl_in;
    endproperty
    property p_ccc_inverse;
        continuous_cathode_calibration == !one_point_loop_sel;
    endproperty
    property p_level_fixed;
        one_point_loop_sel |->
            cathode_drive_level == tvpi2c_pkg::CATHODE_FIXED_LEVEL;
    endproperty
    property p_black_follows;
        black_insert == screen_grid_adjust_mode;
    endproperty
    property p_scan_on;
        vertical_scan_en == 1'b1;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("sda_out not low");
    a_oe_moves_low: assert property (p_oe_moves_low)
        else $error("sda_oe changed while scl high");
    a_ack_holds: assert property (p_ack_holds)
        else $error("sda_oe pulse too short");
    a_ctrl_on_low: assert property (p_ctrl_on_low)
        else $error("control changed while scl high");
    a_ccc_inverse: assert property (p_ccc_inverse)
        else $error("calibration wrong");
    a_level_fixed: assert property (p_level_fixed)
        else $error("level not fixed");
    a_black_follows: assert property (p_black_follows)
        else $error("black insert wrong");
    a_scan_on: assert property (p_scan_on)
        else $error("vertical scan stopped");
    c_one_point: cover property ($rose(one_point_loop_sel));
    c_grid_test: cover property ($rose(screen_grid_adjust_mode));
    c_drive: cover property ($rose(sda_oe));
endmodule : tvpi2c_ctrl_port_asserts
bind tvpi2c_ctrl_port tvpi2c_ctrl_port_asserts #(.WORDS(WORDS))
    i_tvpi2c_ctrl_port_asserts (.*);
`default_nettype wire

/* verification/tvpi2c_master_model.sv */
// bus master model: bit-level tasks called by the testbench
// assumes: resolved data line fed back, pull-up when released
`timescale 1ns/1ps
`default_nettype none
module tvpi2c_master_model
#(
    parameter int T_LOW = 326,
    parameter int T_HIGH = 300
)
(
    input wire logic clk_sys, // system clock
    input wire logic sda, // resolved data line
    output logic scl, // bus clock, idles high
    output logic sda_low // pull data line low
);
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic gap(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : gap
    task automatic bit_io(input logic b, output logic r);
        sda_low <= !b;
        gap(T_LOW / 2);
        scl <= 1'b1;
        gap(T_HIGH);
        r = sda;
        scl <= 1'b0;
        gap(T_LOW / 2);
    endtask : bit_io
    task automatic start();
        sda_low <= 1'b0;
        gap(T_LOW / 2);
        scl <= 1'b1;
        gap(T_HIGH / 2);
        sda_low <= 1'b1;
        gap(T_HIGH / 2);
        scl <= 1'b0;
        gap(T_LOW / 2);
    endtask : start
    task automatic stop();
        sda_low <= 1'b1;
        gap(T_LOW / 2);
        scl <= 1'b1;
        gap(T_HIGH / 2);
        sda_low <= 1'b0;
        gap(T_HIGH);
    endtask : stop
    task automatic wr_byte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(v[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask : wr_byte
    // ack every byte, nack only the last
    task automatic rd_byte(input logic last, output logic [7:0] v);
        logic r;
        for (int i = 0; i < 8; i++)
        begin
            bit_io(1'b1, r);
            v = {v[6:0], r};
        end
        bit_io(last, r);
    endtask : rd_byte
endmodule : tvpi2c_master_model
`default_nettype wire

/* verification/tvpi2c_ctrl_port_tb.sv */
// bench of the control port: writes, refusals, status read
// assumes: master model drives the bus, pull-up on the data line
`timescale 1ns/1ps
`default_nettype none
module tvpi2c_ctrl_port_tb;
    logic clk_sys = 1'b0, sys_rst = 1'b1, scl_in, m_low, sda_in;
    logic sda_out, sda_oe, forced_colour_on, auto_colour_limit_en;
    logic one_point_loop_sel, continuous_cathode_calibration;
    logic wide_blank_en, screen_grid_adjust_mode, black_insert;
    logic vertical_scan_en;
    logic [1:0] ext_input_format_sel, overshoot_ratio;
    logic [3:0] cathode_drive_level;
    logic [7:0] wide_blank_edge_timing, b, d0, d1;
    logic [7:0] status0_in = 8'h00, status2_in = 8'h00;
    logic [7:0] status3_in = 8'h00, status4_in = 8'h00;
    logic cur_in_window_in = 1'b0, cur_high_low_in = 1'b0, a;
    logic [15:0] seed = 16'h98A3;
    logic [7:0] expv [5];
    int fails = 0, n_compared = 0;
    always #2 clk_sys = ~clk_sys;
    assign sda_in = !(m_low || (sda_oe && !sda_out));
    tvpi2c_ctrl_port i_tvpi2c_ctrl_port (.*);
    tvpi2c_master_model i_tvpi2c_master_model (.clk_sys, .sda(sda_in),
        .scl(scl_in), .sda_low(m_low));
    // ========================================================
    // helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [3:0] exp_level(input logic [7:0] c,
        input logic [7:0] o);
        return o[7] ? tvpi2c_pkg::CATHODE_FIXED_LEVEL : c[3:0];
    endfunction : exp_level
    task automatic roll(output logic [7:0] v);
        seed = lfsr(seed);
        v = seed[7:0];
    endtask : roll
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out
    task automatic chk(input string n, input logic [7:0] e,
        input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr_seq(input logic [7:0] sub, input logic [7:0] q[$]);
        logic ack;
        i_tvpi2c_master_model.start();
        i_tvpi2c_master_model.wr_byte({tvpi2c_pkg::SLAVE_ADDR, 1'b0}, ack);
        chk("ack_addr", 8'h01, 8'(ack));
        i_tvpi2c_master_model.wr_byte(sub, ack);
        chk("ack_sub", 8'h01, 8'(ack));
        foreach (q[i])
        begin
            i_tvpi2c_master_model.wr_byte(q[i], ack);
            chk("ack_data", 8'h01, 8'(ack));
        end
        i_tvpi2c_master_model.stop();
    endtask : wr_seq
    // ========================================================
    // main sequence
    initial
    begin
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk("edge_timing", 8'h88, wide_blank_edge_timing);
        for (int i = 0; i < 2; i++)
        begin
            i_tvpi2c_master_model.start();
            i_tvpi2c_master_model.wr_byte(i ? 8'h88 : 8'h00, a);
            i_tvpi2c_master_model.stop();
            chk("nack", 8'h00, 8'(a));
        end
        roll(d0);
        roll(d1);
        wr_seq(tvpi2c_pkg::COLOUR_DECODER_CTRL_A, {d0, d1});
        chk("limit", 8'(d0[1]), 8'(auto_colour_limit_en));
        chk("forced", 8'(d1[0]), 8'(forced_colour_on));
        for (int k = 0; k < 2; k++)
        begin
            roll(d0);
            roll(d1);
            d1[7] = k[0];
            wr_seq(tvpi2c_pkg::CATHODE_CTRL, {d0, d1});
            chk("format", 8'(d1[2:1]), 8'(ext_input_format_sel));
            chk("one_pt", 8'(d1[7]), 8'(one_point_loop_sel));
            chk("ccc", 8'(!d1[7]), 8'(continuous_cathode_calibration));
            chk("wblank", 8'(d1[0]), 8'(wide_blank_en));
            chk("level", 8'(exp_level(d0, d1)), 8'(cathode_drive_level));
        end
        roll(d0);
        wr_seq(tvpi2c_pkg::WIDE_BLANKING_TIMING, {d0});
        chk("edge_timing", d0, wide_blank_edge_timing);
        roll(d0);
        wr_seq(tvpi2c_pkg::FEATURE_CTRL_B, {d0});
        chk("overshoot", 8'(d0[5:4]), 8'(overshoot_ratio));
        roll(d0);
        d0[2] = 1'b1;
        wr_seq(tvpi2c_pkg::DEFLECTION_CTRL, {d0});
        chk("black", 8'h01, 8'(black_insert));
        chk("grid", 8'h01, 8'(screen_grid_adjust_mode));
        chk("scan", 8'h01, 8'(vertical_scan_en));
        foreach (expv[i]) roll(expv[i]);
        roll(b);
        expv[1] = {4'h0, b[0], b[1], 2'b00};
        status0_in <= expv[0];
        status2_in <= expv[2];
        status3_in <= expv[3];
        status4_in <= expv[4];
        cur_in_window_in <= b[0];
        cur_high_low_in <= b[1];
        i_tvpi2c_master_model.start();
        i_tvpi2c_master_model.wr_byte({tvpi2c_pkg::SLAVE_ADDR, 1'b1}, a);
        chk("ack_read", 8'h01, 8'(a));
        for (int i = 0; i < 5; i++)
        begin
            i_tvpi2c_master_model.rd_byte(i == 4, b);
            chk("status", expv[i], b);
        end
        i_tvpi2c_master_model.stop();
        close_out();
    end
    // hang guard: the full sequence needs about 175000 cycles
    initial
    begin
        repeat (300000) @(posedge clk_sys);
        fails++;
        close_out();
    end
endmodule : tvpi2c_ctrl_port_tb
`default_nettype wire
